// *** rtl/cam_aux_io.sv ***
// exposure, trigger echo, strobe and line/frame framing for the aux port
`timescale 1ns/1ps
// Overview of operation
// - in continuous overlapped mode strobe is high exactly while sensor exposes.
// - falling edge on single-ended trigger starts an exposure.
// - line valid is high over the valid part of every line.
// - line valid is low between lines and between frames.
// - each trigger-started exposure gives one 6 us positive echo pulse.
// - the echo pulse begins from the trigger's falling edge.
// - falling edge of differential trigger (P minus N) also starts exposure.
// - frame valid is high over active lines, low between frames.
// - exposure length is 0 to 1000 s in 1 ms steps.
module cam_aux_io #(
   parameter int MS_CYCLES = cam_aux_pkg::EXP_STEP_CYCLES // clocks per ms
) (
   input wire logic CORE_CLK,              // 40 MHz core clock
   input wire logic RESET_N,               // async reset, active low
   input wire logic TRIG_IN,               // single-ended trigger
   input wire logic LVDS_TRIG_P,           // differential trigger, positive
   input wire logic LVDS_TRIG_N,           // differential trigger, negative
   input wire logic CONT_MODE,             // 1 continuous, 0 triggered
   input wire logic [19:0] EXPOSURE_MS,    // exposure length in ms
   input wire logic [10:0] LINE_PIXELS,    // valid clocks per line
   input wire logic [10:0] FRAME_LINES,    // lines per frame
   output logic STROBE_OUT,                // high while exposing, continuous mode only
   output logic TRIG_OUT,                  // trigger echo pulse
   output logic LINE_VALID_OUT,            // line valid
   output logic FRAME_VALID_OUT            // frame valid
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a zero size would wrap to a last count of 2047, so it reads as one
   function automatic logic [10:0] at_least_one(input logic [10:0] v);
      at_least_one = (v == 11'h000) ? 11'h001 : v;
   endfunction : at_least_one

   // ----------------------------------------------------------------
   // trigger inputs
   // ----------------------------------------------------------------
   logic [1:0] trig_level;
   logic [1:0] trig_fall;
   logic trig_any;

   // differential level is the sign of P minus N
   assign trig_level[0] = TRIG_IN;
   assign trig_level[1] = LVDS_TRIG_P & ~LVDS_TRIG_N;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_trig
         trig_fall_detect u_fall (
            .clk(CORE_CLK),
            .rst_n(RESET_N),
            .level_in(trig_level[gi]),
            .fall_pulse(trig_fall[gi])
         );
      end
   endgenerate

   assign trig_any = |trig_fall;

   // ----------------------------------------------------------------
   // exposure control
   // ----------------------------------------------------------------
   cam_aux_pkg::exp_state_t exp_reg, exp_next;
   cam_aux_pkg::rd_state_t rd_reg, rd_next;
   logic [15:0] pre_reg, pre_next;
   logic [19:0] ms_reg, ms_next;
   logic [19:0] exp_len;
   logic start_exp;
   logic trig_start;
   logic launch_rd;

   // out-of-range request is clamped to the 1000 s ceiling
   assign exp_len = (EXPOSURE_MS > cam_aux_pkg::EXP_MAX_MS) ?
                    cam_aux_pkg::EXP_MAX_MS : EXPOSURE_MS;
   // triggers are ignored while an exposure is in progress
   assign trig_start = trig_any && !CONT_MODE &&
                       (exp_reg == cam_aux_pkg::EXP_IDLE);
   assign start_exp = (exp_reg == cam_aux_pkg::EXP_IDLE) &&
                      (CONT_MODE || trig_any);
   assign launch_rd = (exp_reg == cam_aux_pkg::EXP_HOLD) &&
                      (rd_reg == cam_aux_pkg::RD_IDLE);

   always_comb begin
      exp_next = exp_reg;
      pre_next = pre_reg;
      ms_next = ms_reg;
      unique case (exp_reg)
         cam_aux_pkg::EXP_IDLE: begin
            if (start_exp) begin
               pre_next = 16'h0000;
               ms_next = exp_len;
               exp_next = (exp_len == 20'h0_0000) ?
                          cam_aux_pkg::EXP_HOLD : cam_aux_pkg::EXP_RUN;
            end
         end
         cam_aux_pkg::EXP_RUN: begin
            if (pre_reg == 16'(MS_CYCLES - 1)) begin
               pre_next = 16'h0000;
               ms_next = ms_reg - 20'h0_0001;
               if (ms_reg == 20'h0_0001) begin
                  exp_next = cam_aux_pkg::EXP_HOLD;
               end
            end else begin
               pre_next = pre_reg + 16'h0001;
            end
         end
         cam_aux_pkg::EXP_HOLD: begin
            // charge waits here until the previous readout has left
            if (launch_rd) begin
               exp_next = cam_aux_pkg::EXP_IDLE;
            end
         end
         default: begin
            exp_next = cam_aux_pkg::EXP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         exp_reg <= cam_aux_pkg::EXP_IDLE;
         pre_reg <= 16'h0000;
         ms_reg <= 20'h0_0000;
      end else begin
         exp_reg <= exp_next;
         pre_reg <= pre_next;
         ms_reg <= ms_next;
      end
   end

   // ----------------------------------------------------------------
   // trigger echo
   // ----------------------------------------------------------------
   logic echo_reg, echo_next;
   logic [7:0] echo_cnt_reg, echo_cnt_next;

   // a new trigger during the pulse restarts it: still one pulse
   always_comb begin
      echo_next = echo_reg;
      echo_cnt_next = echo_cnt_reg;
      if (trig_start) begin
         echo_next = 1'h1;
         echo_cnt_next = 8'h00;
      end else if (echo_reg) begin
         if (echo_cnt_reg == cam_aux_pkg::ECHO_LAST) begin
            echo_next = 1'h0;
         end else begin
            echo_cnt_next = echo_cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         echo_reg <= 1'h0;
         echo_cnt_reg <= 8'h00;
      end else begin
         echo_reg <= echo_next;
         echo_cnt_reg <= echo_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // readout framing
   // ----------------------------------------------------------------
   logic [10:0] pix_reg, pix_next;
   logic [10:0] line_reg, line_next;
   logic [7:0] gap_reg, gap_next;
   logic [10:0] pix_last;
   logic [10:0] line_last;

   // sizes must stay steady while a frame is being read out
   assign pix_last = at_least_one(LINE_PIXELS) - 11'h001;
   assign line_last = at_least_one(FRAME_LINES) - 11'h001;

   always_comb begin
      rd_next = rd_reg;
      pix_next = pix_reg;
      line_next = line_reg;
      gap_next = gap_reg;
      unique case (rd_reg)
         cam_aux_pkg::RD_IDLE: begin
            if (launch_rd) begin
               pix_next = 11'h000;
               line_next = 11'h000;
               rd_next = cam_aux_pkg::RD_LINE;
            end
         end
         cam_aux_pkg::RD_LINE: begin
            if (pix_reg == pix_last) begin
               pix_next = 11'h000;
               gap_next = 8'h00;
               if (line_reg == line_last) begin
                  rd_next = cam_aux_pkg::RD_FGAP;
               end else begin
                  line_next = line_reg + 11'h001;
                  rd_next = cam_aux_pkg::RD_LGAP;
               end
            end else begin
               pix_next = pix_reg + 11'h001;
            end
         end
         cam_aux_pkg::RD_LGAP: begin
            gap_next = gap_reg + 8'h01;
            if (gap_reg == cam_aux_pkg::LINE_GAP_LAST) begin
               rd_next = cam_aux_pkg::RD_LINE;
            end
         end
         cam_aux_pkg::RD_FGAP: begin
            gap_next = gap_reg + 8'h01;
            if (gap_reg == cam_aux_pkg::FRAME_GAP_LAST) begin
               rd_next = cam_aux_pkg::RD_IDLE;
            end
         end
         default: begin
            rd_next = cam_aux_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_reg <= cam_aux_pkg::RD_IDLE;
         pix_reg <= 11'h000;
         line_reg <= 11'h000;
         gap_reg <= 8'h00;
      end else begin
         rd_reg <= rd_next;
         pix_reg <= pix_next;
         line_reg <= line_next;
         gap_reg <= gap_next;
      end
   end

   // ----------------------------------------------------------------
   // registered pin outputs
   // ----------------------------------------------------------------
   logic strobe_reg, strobe_next;
   logic line_valid_out_reg, line_valid_out_next;
   logic fval_reg, fval_next;

   always_comb begin
      strobe_next = CONT_MODE &&
                    (exp_next == cam_aux_pkg::EXP_RUN);
      line_valid_out_next = (rd_next == cam_aux_pkg::RD_LINE);
      fval_next = (rd_next == cam_aux_pkg::RD_LINE) ||
                  (rd_next == cam_aux_pkg::RD_LGAP);
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         strobe_reg <= 1'h0;
         line_valid_out_reg <= 1'h0;
         fval_reg <= 1'h0;
      end else begin
         strobe_reg <= strobe_next;
         line_valid_out_reg <= line_valid_out_next;
         fval_reg <= fval_next;
      end
   end

   assign STROBE_OUT = strobe_reg;
   assign TRIG_OUT = echo_reg;
   assign LINE_VALID_OUT = line_valid_out_reg;
   assign FRAME_VALID_OUT = fval_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   logic [8:0] echo_hi_reg;
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         echo_hi_reg <= 9'h000;
      end else begin
         echo_hi_reg <= echo_reg ? echo_hi_reg + 9'h001 : 9'h000;
      end
   end

   sequence s_trig_start;
      trig_any && !CONT_MODE && exp_reg == cam_aux_pkg::EXP_IDLE;
   endsequence
   sequence s_exp_begun;
      exp_reg != cam_aux_pkg::EXP_IDLE ##0 echo_reg;
   endsequence

   AST_STROBE_ON: assert property (
      exp_reg == cam_aux_pkg::EXP_RUN && $past(CONT_MODE) |-> strobe_reg)
      else $error("strobe low during continuous exposure");
   AST_STROBE_OFF: assert property (
      exp_reg != cam_aux_pkg::EXP_RUN |-> !strobe_reg)
      else $error("strobe high outside exposure");
   AST_TRIG_STARTS: assert property (
      s_trig_start |=> s_exp_begun)
      else $error("trigger edge did not start exposure and echo");
   AST_LINE_VALID_OUT_LINE: assert property (
      rd_reg == cam_aux_pkg::RD_LINE |-> line_valid_out_reg && fval_reg)
      else $error("line valid low in active line");
   AST_LINE_VALID_OUT_GAPS: assert property (
      rd_reg inside {cam_aux_pkg::RD_LGAP, cam_aux_pkg::RD_FGAP,
                     cam_aux_pkg::RD_IDLE} |-> !line_valid_out_reg)
      else $error("line valid high in a gap");
   AST_ECHO_WIDTH: assert property (
      $fell(echo_reg) |-> echo_hi_reg >= 9'(cam_aux_pkg::ECHO_CYCLES))
      else $error("echo pulse shorter than 6 us");
   AST_ECHO_END: assert property (
      echo_reg && echo_cnt_reg == cam_aux_pkg::ECHO_LAST && !trig_start
      |=> !echo_reg)
      else $error("echo pulse longer than 6 us");
   AST_ECHO_PROMPT: assert property (
      $rose(echo_reg) |-> $past(trig_any))
      else $error("echo without trigger edge");
   AST_DIFF_FALL: assert property (
      $fell(g_trig[1].u_fall.sync_reg) |-> trig_any)
      else $error("differential edge not seen");
   AST_FVAL_GAP: assert property (
      rd_reg inside {cam_aux_pkg::RD_FGAP, cam_aux_pkg::RD_IDLE}
      |-> !fval_reg)
      else $error("frame valid high between frames");
   AST_EXP_RANGE: assert property (
      exp_reg == cam_aux_pkg::EXP_RUN
      |-> ms_reg != 20'h0_0000 && ms_reg <= cam_aux_pkg::EXP_MAX_MS)
      else $error("exposure count out of range");
   AST_ONE_EDGE: assert property (
      trig_fall[0] |=> !trig_fall[0] ##1 !trig_fall[0])
      else $error("single-ended edge seen twice");

endmodule : cam_aux_io

// *** rtl/cam_aux_pkg.sv ***
// constants and state encodings for the camera auxiliary trigger/strobe block
package cam_aux_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 40000;
   // trigger echo width, microseconds
   localparam int ECHO_US = 6;
   localparam int ECHO_CYCLES = ECHO_US * CLK_FREQ_KHZ / 1000;
   // exposure step, microseconds (one millisecond)
   localparam int EXP_STEP_US = 1000;
   localparam int EXP_STEP_CYCLES = EXP_STEP_US * CLK_FREQ_KHZ / 1000;

   // ----------------------------------------------------------------
   // widths and limits
   // ----------------------------------------------------------------
   localparam int MS_W = 20;
   localparam int PRE_W = 16;
   localparam int PIX_W = 11;
   localparam int ECHO_W = 8;
   localparam int GAP_W = 8;
   // longest programmable exposure in milliseconds (1000 s)
   localparam logic [MS_W-1:0] EXP_MAX_MS = 20'hF_4240;
   localparam logic [ECHO_W-1:0] ECHO_LAST = 8'(ECHO_CYCLES - 1);
   localparam logic [GAP_W-1:0] LINE_GAP_LAST = 8'h1F;
   localparam logic [GAP_W-1:0] FRAME_GAP_LAST = 8'h3F;

   // ----------------------------------------------------------------
   // state encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EXP_IDLE = 3'h1,
      EXP_RUN  = 3'h2,
      EXP_HOLD = 3'h4
   } exp_state_t;

   typedef enum logic [3:0] {
      RD_IDLE = 4'h1,
      RD_LINE = 4'h2,
      RD_LGAP = 4'h4,
      RD_FGAP = 4'h8
   } rd_state_t;

endpackage : cam_aux_pkg

// *** rtl/trig_fall_detect.sv ***
// two-stage synchroniser and falling-edge detector for one trigger level
`timescale 1ns/1ps
module trig_fall_detect (
   input wire logic clk,       // core clock
   input wire logic rst_n,     // async reset, active low
   input wire logic level_in,  // asynchronous trigger level
   output logic fall_pulse     // one cycle per high-to-low change
);

   // ----------------------------------------------------------------
   // synchroniser chain
   // ----------------------------------------------------------------
   // reset to low so a line idling low at release gives no false edge
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic prev_reg, prev_next;

   always_comb begin
      meta_next = level_in;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'h0;
         sync_reg <= 1'h0;
         prev_reg <= 1'h0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // edge taken only from the settled stages
   assign fall_pulse = prev_reg & ~sync_reg;

endmodule : trig_fall_detect

// *** sim/trig_src.sv ***
// behavioural external trigger source for the aux port
`timescale 1ns/1ps
module trig_src (
   input wire logic clk,  // core clock, paces the edges
   output logic trig,     // single-ended trigger, idle high
   output logic diff_p,   // differential trigger, positive leg
   output logic diff_n    // differential trigger, negative leg
);
   // idle high so a release from reset never looks like an edge
   initial begin
      trig = 1'b1;
      diff_p = 1'b1;
      diff_n = 1'b0;
   end

   // ----------------------------------------------------------------
   // edges: kind 0 single-ended, 1 differential, 2 both at once
   // ----------------------------------------------------------------
   task automatic drop(input int kind);
      @(negedge clk);
      if (kind != 1) trig = 1'b0;
      if (kind != 0) begin
         diff_p = 1'b0;
         diff_n = 1'b1;
      end
   endtask : drop

   task automatic rise();
      @(negedge clk);
      trig = 1'b1;
      diff_p = 1'b1;
      diff_n = 1'b0;
   endtask : rise
endmodule : trig_src

// *** sim/testbench.sv ***
// self-checking bench for the aux trigger, echo, strobe and framing block
`timescale 1ns/1ps
module testbench;
   localparam int MSC = 10;
   localparam int ECHO = 240;
   localparam int LGAP = 32;
   localparam int CEIL = 20000;
   localparam int STR = 0, STW = 1, STN = 2, TRR = 3, TRW = 4, TRN = 5;
   localparam int LVH = 6, LVN = 7, LVB = 8, FVH = 9, FVN = 10;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cont_mode = 1'b0;
   logic [19:0] exposure_ms = 20'h0_0000;
   logic [10:0] line_pixels = 11'h001;
   logic [10:0] frame_lines = 11'h001;
   logic trig_in, lvds_p, lvds_n, strobe, trig_out, lv, fv, lv_q, fv_q;
   int c[11];
   int seed = 32'hc8b2_bb1b;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;

   always #12.5 core_clk = ~core_clk;

   cam_aux_io #(.MS_CYCLES(MSC)) dut_u (.CORE_CLK(core_clk),
      .RESET_N(reset_n), .TRIG_IN(trig_in), .LVDS_TRIG_P(lvds_p),
      .LVDS_TRIG_N(lvds_n), .CONT_MODE(cont_mode),
      .EXPOSURE_MS(exposure_ms), .LINE_PIXELS(line_pixels),
      .FRAME_LINES(frame_lines), .STROBE_OUT(strobe), .TRIG_OUT(trig_out),
      .LINE_VALID_OUT(lv), .FRAME_VALID_OUT(fv));

   trig_src src_u (.clk(core_clk), .trig(trig_in), .diff_p(lvds_p),
      .diff_n(lvds_n));

   // ----------------------------------------------------------------
   // monitor: pulse widths and framing counts, plus the hang guard
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      cyc++;
      if (strobe === 1'b1) c[STR]++;
      else if (c[STR] != 0) begin
         c[STW] = c[STR];
         c[STN]++;
         c[STR] = 0;
      end
      if (trig_out === 1'b1) c[TRR]++;
      else if (c[TRR] != 0) begin
         c[TRW] = c[TRR];
         c[TRN]++;
         c[TRR] = 0;
      end
      if (lv === 1'b1) c[LVH]++;
      if (lv === 1'b1 && lv_q !== 1'b1) c[LVN]++;
      if (lv === 1'b1 && fv !== 1'b1) c[LVB]++;
      if (fv === 1'b1) c[FVH]++;
      if (fv !== 1'b1 && fv_q === 1'b1) c[FVN]++;
      lv_q = lv;
      fv_q = fv;
      if (cyc == CEIL) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, CEIL);
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // checking and expectations
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic cmp_cnt(input int got, input int exp);
      checks++;
      if (got != exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_cnt

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit

   // zero sizes count as one
   function automatic int eff(input int x);
      return (x == 0) ? 1 : x;
   endfunction : eff

   function automatic int fv_len(input int p, input int l);
      return eff(l) * eff(p) + (eff(l) - 1) * LGAP;
   endfunction : fv_len

   task automatic do_reset(input logic mode);
      @(negedge core_clk);
      reset_n = 1'b0;
      cont_mode = mode;
      repeat (20) @(negedge core_clk);
      reset_n = 1'b1;
   endtask : do_reset

   task automatic run_trig(input int kind, input int e, input int px,
      input int ln);
      src_u.rise();
      exposure_ms = 20'(e);
      line_pixels = 11'(px);
      frame_lines = 11'(ln);
      foreach (c[i]) c[i] = 0;
      repeat (3) @(posedge core_clk);
      src_u.drop(kind);
      repeat (2) @(posedge core_clk);
      #1 cmp_bit(trig_out, 1'b0);
      @(posedge core_clk);
      #1 cmp_bit(trig_out, 1'b1);
      // retrigger while still exposing must be ignored
      src_u.rise();
      repeat (2) @(posedge core_clk);
      src_u.drop(kind);
      for (int i = 0; i < 3000; i++) begin
         if (c[FVN] == 1 && trig_out === 1'b0) break;
         @(negedge core_clk);
      end
      // echo width and count close only at the edge after the pulse drops
      @(negedge core_clk);
      cmp_cnt(c[TRW], ECHO);
      cmp_cnt(c[TRN], 1);
      cmp_cnt(c[LVN], eff(ln));
      cmp_cnt(c[LVH], eff(ln) * eff(px));
      cmp_cnt(c[FVH], fv_len(px, ln));
      cmp_cnt(c[LVB], 0);
      cmp_cnt(c[STN], 0);
   endtask : run_trig

   task automatic run_cont(input int e, input int px, input int ln);
      src_u.rise();
      exposure_ms = 20'(e);
      line_pixels = 11'(px);
      frame_lines = 11'(ln);
      do_reset(1'b1);
      foreach (c[i]) c[i] = 0;
      src_u.drop(2);
      for (int i = 0; i < 5000; i++) begin
         if (c[FVN] == 3) break;
         @(negedge core_clk);
      end
      cmp_cnt(c[TRN] + c[TRR], 0);
      cmp_cnt(c[STW], e * MSC);
      cmp_cnt(int'(c[STN] > 1), int'(e > 0));
      cmp_cnt(c[LVN], 3 * eff(ln));
      cmp_cnt(c[LVB], 0);
   endtask : run_cont

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int e;
      int px;
      int ln;
      do_reset(1'b0);
      run_trig(0, 2, 1, 1);
      run_trig(2, 5, 0, 3);
      for (int k = 0; k < 6; k++) begin
         e = 2 + $unsigned($random(seed)) % 4;
         px = $unsigned($random(seed)) % 9;
         ln = 1 + $unsigned($random(seed)) % 3;
         run_trig(k % 3, e, px, ln);
      end
      run_cont(3, 4, 2);
      run_cont(0, 2, 2);
      give_verdict();
   end
endmodule : testbench
